// file: hw/phy_port_regs_pkg.sv
package phy_port_regs_pkg;

    // register byte offsets, one 16-bit word each
    localparam logic [11:0] ADDR_BASIC_STATUS = 12'h004e;
    localparam logic [11:0] ADDR_ID_LOW       = 12'h0050;
    localparam logic [11:0] ADDR_ID_HIGH      = 12'h0052;
    localparam logic [11:0] ADDR_ADVERTISE    = 12'h0054;
    localparam logic [11:0] ADDR_PARTNER      = 12'h0056;
    localparam logic [11:0] ADDR_SPECIAL      = 12'h0066;

    // identification words, values are arbitrary
    localparam logic [15:0] ID_LOW_DEFAULT    = 16'h5a5a;
    localparam logic [15:0] ID_HIGH_DEFAULT   = 16'ha5a5;

    // basic status: bits 14..11 and 3 fixed at one, bits 5, 4 and 2 live, the rest fixed at zero
    localparam logic [15:0] BASIC_FIXED       = 16'h7808;
    localparam logic [15:0] BASIC_FIXED_MASK  = 16'hffcb;
    localparam int          BSR_AN_DONE_BIT   = 5;
    localparam int          BSR_FAR_FAULT_BIT = 4;
    localparam int          BSR_LINK_BIT      = 2;

    // advertisement and partner ability fields
    localparam logic [15:0] SELECTOR_8023     = 16'h0001;
    localparam logic [15:0] ABILITY_MASK      = 16'h05e0;
    localparam int          ANA_PAUSE_BIT     = 10;
    localparam int          ANA_100FD_BIT     = 8;
    localparam int          ANA_100HD_BIT     = 7;
    localparam int          ANA_10FD_BIT      = 6;
    localparam int          ANA_10HD_BIT      = 5;

    // special control and status fields
    localparam logic [15:0] SPECIAL_MASK      = 16'h003e;
    localparam int          SPC_POL_REV_BIT   = 5;
    localparam int          SPC_MDIX_BIT      = 4;
    localparam int          SPC_FORCE_BIT     = 3;
    localparam int          SPC_EEE_OFF_BIT   = 2;
    localparam int          SPC_LOOP_BIT      = 1;

    // aliased fields as seen from the two other registers
    localparam int          CR4_PAUSE_BIT     = 4;
    localparam int          CR4_100FD_BIT     = 3;
    localparam int          CR4_100HD_BIT     = 2;
    localparam int          CR4_10FD_BIT      = 1;
    localparam int          CR4_10HD_BIT      = 0;
    localparam int          DIAG_FORCE_BIT    = 11;
    localparam int          DIAG_LOOP_BIT     = 9;

    localparam int          STATUS_W          = 10;

    typedef struct packed {
        logic an_done;
        logic far_fault;
        logic link_up;
        logic pol_rev;
        logic mdix;
        logic lp_pause;
        logic lp_100fd;
        logic lp_100hd;
        logic lp_10fd;
        logic lp_10hd;
    } status_in_t;

    typedef struct packed {
        logic adv_pause;
        logic adv_100fd;
        logic adv_100hd;
        logic adv_10fd;
        logic adv_10hd;
        logic force_link;
        logic eee10_disable;
        logic remote_loop;
    } ctrl_out_t;

    localparam ctrl_out_t CTRL_RESET = '{
        adv_pause:     1'b1,
        adv_100fd:     1'b1,
        adv_100hd:     1'b1,
        adv_10fd:      1'b1,
        adv_10hd:      1'b1,
        force_link:    1'b0,
        eee10_disable: 1'b1,
        remote_loop:   1'b0
    };

endpackage

// file: hw/bit_sync2.sv
`timescale 1ns/1ps
`default_nettype none

module bit_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    input  wire logic [WIDTH-1:0] d_i,
    output var  logic [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] q_reg;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_reg <= '0;
            q_reg    <= '0;
        end else begin
            meta_reg <= d_i;
            q_reg    <= meta_reg;
        end
    end

    assign q_o = q_reg;

endmodule

`default_nettype wire

// file: hw/phy_port_status_adv_regs.sv
`timescale 1ns/1ps
`default_nettype none

module phy_port_status_adv_regs
    import phy_port_regs_pkg::*;
#(
    parameter logic [15:0] ID_LOW  = ID_LOW_DEFAULT,
    parameter logic [15:0] ID_HIGH = ID_HIGH_DEFAULT
) (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        req_i,
    input  wire logic        wr_i,
    input  wire logic [11:0] addr_i,
    input  wire logic [1:0]  be_i,
    input  wire logic [15:0] wdata_i,
    output var  logic        ack_o,
    output var  logic [15:0] rdata_o,
    input  wire logic        cr4_we_i,
    input  wire logic [1:0]  cr4_be_i,
    input  wire logic [15:0] cr4_wdata_i,
    input  wire logic        diag_we_i,
    input  wire logic [1:0]  diag_be_i,
    input  wire logic [15:0] diag_wdata_i,
    input  wire status_in_t  phy_status_i,
    output var  ctrl_out_t   ctrl_o
);

    function automatic logic [15:0] place_bit(input logic b, input int pos);
        logic [15:0] w;
        w = '0;
        w[pos] = b;
        return w;
    endfunction

    function automatic logic hit(input logic [11:0] a, input logic [11:0] reg_addr);
        return a[11:1] == reg_addr[11:1];
    endfunction

    // pick the written bit when its byte lane is enabled
    function automatic logic lane_bit(input logic [1:0] be, input logic [15:0] d, input int pos,
                                      input logic keep);
        logic en;
        en = (pos >= 8) ? be[1] : be[0];
        return en ? d[pos] : keep;
    endfunction

    logic [STATUS_W-1:0] status_sync;
    status_in_t          stat;
    ctrl_out_t           ctrl_reg;
    ctrl_out_t           ctrl_next;
    logic                ack_reg;
    logic [15:0]         rdata_reg;

    bit_sync2 #(
        .WIDTH (STATUS_W)
    ) u_status_sync (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .d_i      (phy_status_i),
        .q_o      (status_sync)
    );

    assign stat = status_in_t'(status_sync);

    // address decode
    wire hit_basic   = hit(addr_i, ADDR_BASIC_STATUS);
    wire hit_id_low  = hit(addr_i, ADDR_ID_LOW);
    wire hit_id_high = hit(addr_i, ADDR_ID_HIGH);
    wire hit_adv     = hit(addr_i, ADDR_ADVERTISE);
    wire hit_partner = hit(addr_i, ADDR_PARTNER);
    wire hit_special = hit(addr_i, ADDR_SPECIAL);
    wire rd_en       = req_i && !wr_i;
    wire wr_adv      = req_i && wr_i && hit_adv;
    wire wr_special  = req_i && wr_i && hit_special;

    // read words
    wire [15:0] basic_word = BASIC_FIXED
                           | place_bit(stat.an_done, BSR_AN_DONE_BIT)
                           | place_bit(stat.far_fault, BSR_FAR_FAULT_BIT)
                           | place_bit(stat.link_up, BSR_LINK_BIT);

    wire [15:0] adv_word = SELECTOR_8023
                         | place_bit(ctrl_reg.adv_pause, ANA_PAUSE_BIT)
                         | place_bit(ctrl_reg.adv_100fd, ANA_100FD_BIT)
                         | place_bit(ctrl_reg.adv_100hd, ANA_100HD_BIT)
                         | place_bit(ctrl_reg.adv_10fd, ANA_10FD_BIT)
                         | place_bit(ctrl_reg.adv_10hd, ANA_10HD_BIT);

    wire [15:0] partner_word = SELECTOR_8023
                             | place_bit(stat.lp_pause, ANA_PAUSE_BIT)
                             | place_bit(stat.lp_100fd, ANA_100FD_BIT)
                             | place_bit(stat.lp_100hd, ANA_100HD_BIT)
                             | place_bit(stat.lp_10fd, ANA_10FD_BIT)
                             | place_bit(stat.lp_10hd, ANA_10HD_BIT);

    wire [15:0] special_word = place_bit(stat.pol_rev, SPC_POL_REV_BIT)
                             | place_bit(stat.mdix, SPC_MDIX_BIT)
                             | place_bit(ctrl_reg.force_link, SPC_FORCE_BIT)
                             | place_bit(ctrl_reg.eee10_disable, SPC_EEE_OFF_BIT)
                             | place_bit(ctrl_reg.remote_loop, SPC_LOOP_BIT);

    // unmapped words fall through to zero
    wire [15:0] read_word = hit_basic   ? basic_word   :
                            hit_id_low  ? ID_LOW       :
                            hit_id_high ? ID_HIGH      :
                            hit_adv     ? adv_word     :
                            hit_partner ? partner_word :
                            hit_special ? special_word :
                            16'h0000;

    // shared storage: aliasing register's write first, then the host port, which wins
    always_comb begin
        ctrl_next = ctrl_reg;
        if (cr4_we_i) begin
            ctrl_next.adv_pause = lane_bit(cr4_be_i, cr4_wdata_i, CR4_PAUSE_BIT, ctrl_reg.adv_pause);
            ctrl_next.adv_100fd = lane_bit(cr4_be_i, cr4_wdata_i, CR4_100FD_BIT, ctrl_reg.adv_100fd);
            ctrl_next.adv_100hd = lane_bit(cr4_be_i, cr4_wdata_i, CR4_100HD_BIT, ctrl_reg.adv_100hd);
            ctrl_next.adv_10fd  = lane_bit(cr4_be_i, cr4_wdata_i, CR4_10FD_BIT, ctrl_reg.adv_10fd);
            ctrl_next.adv_10hd  = lane_bit(cr4_be_i, cr4_wdata_i, CR4_10HD_BIT, ctrl_reg.adv_10hd);
        end
        if (diag_we_i) begin
            ctrl_next.force_link  = lane_bit(diag_be_i, diag_wdata_i, DIAG_FORCE_BIT,
                                             ctrl_reg.force_link);
            ctrl_next.remote_loop = lane_bit(diag_be_i, diag_wdata_i, DIAG_LOOP_BIT,
                                             ctrl_reg.remote_loop);
        end
        if (wr_adv) begin
            ctrl_next.adv_pause = lane_bit(be_i, wdata_i, ANA_PAUSE_BIT, ctrl_next.adv_pause);
            ctrl_next.adv_100fd = lane_bit(be_i, wdata_i, ANA_100FD_BIT, ctrl_next.adv_100fd);
            ctrl_next.adv_100hd = lane_bit(be_i, wdata_i, ANA_100HD_BIT, ctrl_next.adv_100hd);
            ctrl_next.adv_10fd  = lane_bit(be_i, wdata_i, ANA_10FD_BIT, ctrl_next.adv_10fd);
            ctrl_next.adv_10hd  = lane_bit(be_i, wdata_i, ANA_10HD_BIT, ctrl_next.adv_10hd);
        end
        if (wr_special) begin
            ctrl_next.force_link    = lane_bit(be_i, wdata_i, SPC_FORCE_BIT,
                                               ctrl_next.force_link);
            ctrl_next.eee10_disable = lane_bit(be_i, wdata_i, SPC_EEE_OFF_BIT,
                                               ctrl_next.eee10_disable);
            ctrl_next.remote_loop   = lane_bit(be_i, wdata_i, SPC_LOOP_BIT,
                                               ctrl_next.remote_loop);
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_reg  <= CTRL_RESET;
            ack_reg   <= 1'b0;
            rdata_reg <= 16'h0000;
        end else begin
            ctrl_reg  <= ctrl_next;
            ack_reg   <= req_i;
            rdata_reg <= rd_en ? read_word : 16'h0000;
        end
    end

    assign ack_o   = ack_reg;
    assign rdata_o = rdata_reg;
    assign ctrl_o  = ctrl_reg;

    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    wire rd_basic   = rd_en && hit_basic;
    wire rd_adv     = rd_en && hit_adv;
    wire rd_partner = rd_en && hit_partner;
    wire rd_special = rd_en && hit_special;
    wire rd_resv    = rd_en && !(hit_basic || hit_id_low || hit_id_high || hit_adv
                                 || hit_partner || hit_special);

    basic_fixed_a: assert property (rd_basic |=> (rdata_o & BASIC_FIXED_MASK) == BASIC_FIXED)
        else $error("basic status fixed bits wrong");
    basic_live_a: assert property (rd_basic |=> rdata_o[BSR_AN_DONE_BIT] == $past(stat.an_done)
                                   && rdata_o[BSR_FAR_FAULT_BIT] == $past(stat.far_fault)
                                   && rdata_o[BSR_LINK_BIT] == $past(stat.link_up))
        else $error("basic status live bits wrong");
    ext_cap_zero_a: assert property (rd_basic |=> !rdata_o[0] && rdata_o[3])
        else $error("capability bits wrong");
    id_words_a: assert property (rd_en && hit_id_low ##1 rd_en && hit_id_high
                                 |-> rdata_o == ID_LOW ##1 rdata_o == ID_HIGH)
        else $error("identifier words wrong");
    adv_write_a: assert property (wr_adv && be_i == 2'b11 && !cr4_we_i
                                  |=> ctrl_o.adv_pause == $past(wdata_i[ANA_PAUSE_BIT])
                                  && ctrl_o.adv_10hd == $past(wdata_i[ANA_10HD_BIT]))
        else $error("advertisement write lost");
    adv_fixed_a: assert property (rd_adv |=> (rdata_o & ~ABILITY_MASK) == SELECTOR_8023)
        else $error("advertisement fixed bits wrong");
    partner_a: assert property (rd_partner |=> (rdata_o & ~ABILITY_MASK) == SELECTOR_8023
                                && rdata_o[ANA_PAUSE_BIT] == $past(stat.lp_pause)
                                && rdata_o[ANA_100FD_BIT] == $past(stat.lp_100fd))
        else $error("partner ability wrong");
    special_stat_a: assert property (rd_special |=> (rdata_o & ~SPECIAL_MASK) == 16'h0000
                                     && rdata_o[SPC_POL_REV_BIT] == $past(stat.pol_rev)
                                     && rdata_o[SPC_MDIX_BIT] == $past(stat.mdix))
        else $error("special status wrong");
    diag_alias_a: assert property (diag_we_i && diag_be_i[1] && !wr_special
                                   ##1 rd_special
                                   |=> rdata_o[SPC_FORCE_BIT] == $past(diag_wdata_i[DIAG_FORCE_BIT], 2)
                                   && rdata_o[SPC_LOOP_BIT] == $past(diag_wdata_i[DIAG_LOOP_BIT], 2))
        else $error("alias write not seen");
    eee_write_a: assert property (wr_special && be_i[0]
                                  |=> ctrl_o.eee10_disable == $past(wdata_i[SPC_EEE_OFF_BIT]))
        else $error("energy mode write lost");
    resv_read_a: assert property (rd_resv |=> rdata_o == 16'h0000 && ack_o)
        else $error("reserved read not zero");
    resv_write_a: assert property (req_i && wr_i && !hit_adv && !hit_special
                                   && !cr4_we_i && !diag_we_i |=> $stable(ctrl_o))
        else $error("reserved write changed state");

    link_read_c: cover property (rd_basic && stat.link_up ##1 rdata_o[BSR_LINK_BIT]);
    adv_write_c: cover property (wr_adv ##1 rd_adv);
    alias_c: cover property (cr4_we_i ##1 rd_adv);
    resv_c: cover property (rd_resv);

endmodule

`default_nettype wire

// file: dv/phy_port_status_adv_regs_test.sv
`timescale 1ns/1ps
`default_nettype none

module phy_port_status_adv_regs_test import phy_port_regs_pkg::*;;

    logic        clk_i;
    logic        resetn_i;
    logic        req;
    logic        wr;
    logic [11:0] addr;
    logic [1:0]  be;
    logic [15:0] wdata;
    logic        ack;
    logic [15:0] rdata;
    logic        cr4_we;
    logic [1:0]  cr4_be;
    logic [15:0] cr4_wdata;
    logic        diag_we;
    logic [1:0]  diag_be;
    logic [15:0] diag_wdata;
    status_in_t  status;
    ctrl_out_t   ctrl;
    logic [15:0] q;
    logic [9:0]  s;
    int          failures;
    int          check_count;
    int          cycles;

    phy_port_status_adv_regs u_phy_port_status_adv_regs (
        .clk_i        (clk_i),
        .resetn_i     (resetn_i),
        .req_i        (req),
        .wr_i         (wr),
        .addr_i       (addr),
        .be_i         (be),
        .wdata_i      (wdata),
        .ack_o        (ack),
        .rdata_o      (rdata),
        .cr4_we_i     (cr4_we),
        .cr4_be_i     (cr4_be),
        .cr4_wdata_i  (cr4_wdata),
        .diag_we_i    (diag_we),
        .diag_be_i    (diag_be),
        .diag_wdata_i (diag_wdata),
        .phy_status_i (status),
        .ctrl_o       (ctrl)
    );

    always #5 clk_i = ~clk_i;

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // hang guard, the whole sequence needs a few hundred cycles
    always @(posedge clk_i) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            failures = failures + 1;
            give_verdict();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count = check_count + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_ctrl(input string what, input logic [7:0] exp);
        check_count = check_count + 1;
        if (ctrl !== exp) begin
            failures = failures + 1;
            $display("ERROR %s expected %h seen %h", what, exp, ctrl);
        end
    endtask

    // one request pulse, answer sampled in the ack cycle
    task automatic acc(input logic w, input logic [11:0] a, input logic [1:0] b,
                       input logic [15:0] d);
        @(posedge clk_i);
        #1;
        req = 1'b1;
        wr = w;
        addr = a;
        be = b;
        wdata = d;
        @(posedge clk_i);
        #1;
        q = rdata;
        req = 1'b0;
        wr = 1'b0;
        chk("ack", 16'h0001, {15'h0000, ack});
    endtask

    task automatic rd(input string what, input logic [11:0] a, input logic [15:0] exp);
        acc(1'b0, a, 2'b00, 16'h0000);
        chk(what, exp, q);
    endtask

    task automatic wrt(input logic [11:0] a, input logic [1:0] b, input logic [15:0] d);
        acc(1'b1, a, b, d);
        chk("write rdata", 16'h0000, q);
    endtask

    // write pulse from a neighbouring bank that shares the storage
    task automatic alias_wr(input logic diag, input logic [1:0] b, input logic [15:0] d);
        @(posedge clk_i);
        #1;
        if (diag) begin
            diag_we = 1'b1;
            diag_be = b;
            diag_wdata = d;
        end else begin
            cr4_we = 1'b1;
            cr4_be = b;
            cr4_wdata = d;
        end
        @(posedge clk_i);
        #1;
        diag_we = 1'b0;
        cr4_we = 1'b0;
    endtask

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask

    initial begin
        clk_i = 1'b0;
        resetn_i = 1'b0;
        req = 1'b0;
        wr = 1'b0;
        addr = 12'h000;
        be = 2'b00;
        wdata = 16'h0000;
        cr4_we = 1'b0;
        cr4_be = 2'b00;
        cr4_wdata = 16'h0000;
        diag_we = 1'b0;
        diag_be = 2'b00;
        diag_wdata = 16'h0000;
        status = '0;
        failures = 0;
        check_count = 0;
        cycles = 0;
        repeat (8) @(posedge clk_i);
        #1 resetn_i = 1'b1;
        chk_ctrl("ctrl reset", 8'hfa);
        rd("basic", ADDR_BASIC_STATUS, 16'h7808);
        rd("id low", ADDR_ID_LOW, ID_LOW_DEFAULT);
        rd("id high", ADDR_ID_HIGH, ID_HIGH_DEFAULT);
        rd("advertise", ADDR_ADVERTISE, 16'h05e1);
        rd("partner", ADDR_PARTNER, 16'h0001);
        rd("special", ADDR_SPECIAL, 16'h0004);
        end_test("reset values");
        // each live status input alone, then all together
        for (int i = 0; i <= 10; i++) begin
            s = (i == 10) ? 10'h3ff : 10'(1 << i);
            status = status_in_t'(s);
            repeat (3) @(posedge clk_i);
            rd("basic live", ADDR_BASIC_STATUS,
               16'h7808 | {10'h000, s[9], s[8], 1'b0, s[7], 2'b00});
            rd("partner live", ADDR_PARTNER, {5'h00, s[4], 1'b0, s[3:0], 5'h01});
            rd("special live", ADDR_SPECIAL, {10'h000, s[6], s[5], 4'h4});
        end
        status = '0;
        repeat (3) @(posedge clk_i);
        end_test("live status");
        wrt(ADDR_ADVERTISE, 2'b11, 16'h0000);
        rd("adv cleared", ADDR_ADVERTISE, 16'h0001);
        chk_ctrl("ctrl adv clear", 8'h02);
        wrt(ADDR_ADVERTISE, 2'b01, 16'hffff);
        rd("adv low lane", ADDR_ADVERTISE, 16'h00e1);
        wrt(ADDR_ADVERTISE, 2'b11, 16'hffff);
        rd("adv set", ADDR_ADVERTISE, 16'h05e1);
        wrt(ADDR_PARTNER, 2'b11, 16'hffff);
        rd("partner ro", ADDR_PARTNER, 16'h0001);
        wrt(ADDR_BASIC_STATUS, 2'b11, 16'h0000);
        rd("basic ro", ADDR_BASIC_STATUS, 16'h7808);
        wrt(ADDR_SPECIAL, 2'b11, 16'hffff);
        rd("special set", ADDR_SPECIAL, 16'h000e);
        chk_ctrl("ctrl special set", 8'hff);
        wrt(ADDR_SPECIAL, 2'b11, 16'h0000);
        rd("special clear", ADDR_SPECIAL, 16'h0000);
        end_test("host writes");
        alias_wr(1'b0, 2'b01, 16'h000a);
        rd("adv via cr4", ADDR_ADVERTISE, 16'h0141);
        alias_wr(1'b0, 2'b10, 16'h001f);
        rd("cr4 lane off", ADDR_ADVERTISE, 16'h0141);
        alias_wr(1'b1, 2'b10, 16'h0a00);
        rd("special via diag", ADDR_SPECIAL, 16'h000a);
        chk_ctrl("ctrl alias", 8'h55);
        alias_wr(1'b1, 2'b01, 16'h0000);
        rd("diag lane off", ADDR_SPECIAL, 16'h000a);
        end_test("aliases");
        for (int a = 12'h058; a <= 12'h06a; a += 2) begin
            if (a != 12'h066) begin
                wrt(12'(a), 2'b11, 16'hffff);
                rd("reserved", 12'(a), 16'h0000);
            end
        end
        rd("adv kept", ADDR_ADVERTISE, 16'h0141);
        rd("special kept", ADDR_SPECIAL, 16'h000a);
        end_test("reserved");
        @(posedge clk_i);
        #1 resetn_i = 1'b0;
        repeat (2) @(posedge clk_i);
        #1 resetn_i = 1'b1;
        chk_ctrl("ctrl second reset", 8'hfa);
        rd("adv second reset", ADDR_ADVERTISE, 16'h05e1);
        rd("special second reset", ADDR_SPECIAL, 16'h0004);
        end_test("second reset");
        give_verdict();
    end

endmodule

`default_nettype wire
